//--- design/trace_detector_and_hold.sv
// Per-pixel detector, multi-sweep trace hold and burst capture fold with APB registers
//
// Contract
// R1 - Live mode writes each point of the current sweep as produced.
// R2 - Max mode keeps per point the largest level since accumulation began.
// R3 - Min mode keeps per point the lowest level across sweeps.
// R4 - Average mode outputs per point the mean of a chosen sweep count.
// R5 - Difference mode subtracts a stored reference trace point by point.
// R6 - Peak detector outputs the largest sample of each pixel.
// R7 - Sample detector outputs one sample of each pixel, unprocessed.
// R8 - Mean detector outputs the average of each pixel's samples.
// R9 - Minimum detector outputs the lowest sample of each pixel.
// R10 - Detector resets to peak.
// R11 - Detector and trace mode are chosen independently, any combination.
// R12 - Video smoothing runs before the per-pixel detector.
// R13 - Smoothing and averaging work in log or linear domain, selectable.
// R14 - Four sweep modes: fast, accurate, pure swept, burst capture.
// R15 - Burst mode folds traces into a maximum, presented up to eight per second.
// R16 - Burst mode handles 20,000 traces per second, missing no 200 us signal.
// R17 - Burst mode holds tuning fixed, no retuning during a sweep.
// R18 - Burst mode limits span to 15 MHz.
// R19 - Max trace mode may run on top of burst, accumulating burst results.
// R20 - Mode, detector, span or sweep mode change or restart clears accumulators.
// R21 - Sweep samples split evenly over pixels; pixel end signalled to detector.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module trace_detector_and_hold
    import trace_pkg::*;
#(
    parameter int NPTS = 256,
    parameter int BURST_UPDATE = trace_pkg::BURST_UPDATE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sweep_start,
    input wire logic sample_valid,
    input wire trace_pkg::sample_t sample,
    output logic point_valid,
    output trace_pkg::trace_point_t point,
    output logic tune_hold,
    output logic [23:0] span_eff_khz
);
    import trace_pkg::*;
    localparam int PW = $clog2(NPTS);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    detector_t det_q;
    trace_mode_t mode_q;
    sweep_mode_t swm_q;
    logic lin_q, clear_q, store_ref_q;
    logic [3:0] spp_log2_q, avg_log2_q, smooth_q;
    logic [23:0] span_q;
    logic [15:0] sweep_cnt_q;
    logic wr, rd_setup, cfg_change;

    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pready = 1'b1;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CTRL) || (a == OFS_SPP_LOG2) || (a == OFS_AVG_LOG2)
              || (a == OFS_SPAN) || (a == OFS_SMOOTH) || (a == OFS_STATUS)
              || (a == OFS_CMD);
    endfunction : mapped

    always_comb begin
        cfg_change = 1'b0;
        if (wr && paddr == OFS_CTRL) begin
            // Only fields whose value changes, or the restart bit, force a clear
            cfg_change = (pwdata[CTRL_DET_LSB +: 2] != det_q)
                      || (pwdata[CTRL_MODE_LSB +: 3] != mode_q)
                      || (pwdata[CTRL_SWEEP_LSB +: 2] != swm_q)
                      || (pwdata[CTRL_LIN_BIT] != lin_q)
                      || pwdata[CTRL_RESTART_BIT];
        end else if (wr && paddr == OFS_SPAN) begin
            cfg_change = pwdata[23:0] != span_q;
        end else if (wr && (paddr == OFS_SPP_LOG2 || paddr == OFS_AVG_LOG2)) begin
            cfg_change = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_q <= DET_RST; // [R10]
            mode_q <= TM_LIVE;
            swm_q <= SW_FAST;
            lin_q <= 1'b0;
            spp_log2_q <= SPP_LOG2_RST;
            avg_log2_q <= AVG_LOG2_RST;
            smooth_q <= SMOOTH_RST;
            span_q <= SPAN_RST;
        end else if (wr) begin
            case (paddr)
                OFS_CTRL: begin
                    // Separate fields, so every detector pairs with every mode [R11]
                    det_q <= detector_t'(pwdata[CTRL_DET_LSB +: 2]);
                    mode_q <= (pwdata[CTRL_MODE_LSB +: 3] > 3'(TM_DIFF)) ? TM_LIVE
                            : trace_mode_t'(pwdata[CTRL_MODE_LSB +: 3]);
                    swm_q <= sweep_mode_t'(pwdata[CTRL_SWEEP_LSB +: 2]); // [R14]
                    lin_q <= pwdata[CTRL_LIN_BIT]; // [R13]
                end
                OFS_SPP_LOG2: spp_log2_q <= pwdata[3:0];
                OFS_AVG_LOG2: avg_log2_q <= pwdata[3:0];
                OFS_SPAN: span_q <= pwdata[23:0];
                OFS_SMOOTH: smooth_q <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_q <= 1'b1;
            store_ref_q <= 1'b0;
        end else begin
            clear_q <= cfg_change; // [R20]
            store_ref_q <= wr && paddr == OFS_CMD && pwdata[CMD_STORE_REF_BIT];
        end
    end

    // Read data is captured in the setup phase so it leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            pslverr <= !mapped(paddr);
            case (paddr)
                OFS_CTRL: prdata <= {24'h000000, lin_q, swm_q, mode_q, det_q};
                OFS_SPP_LOG2: prdata <= {28'h0000000, spp_log2_q};
                OFS_AVG_LOG2: prdata <= {28'h0000000, avg_log2_q};
                OFS_SPAN: prdata <= {8'h00, span_q};
                OFS_SMOOTH: prdata <= {28'h0000000, smooth_q};
                OFS_STATUS: prdata <= {15'h0000, swm_q == SW_BURST, sweep_cnt_q};
                default: prdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tuning and span
    assign tune_hold = swm_q == SW_BURST; // [R17]
    assign span_eff_khz = (tune_hold && span_q > BURST_SPAN_MAX_KHZ)
                        ? BURST_SPAN_MAX_KHZ : span_q; // [R18]

    ////////////////////////////////////////////////////////////////////////////
    // Smoothing ahead of detection
    logic sm_valid;
    logic [15:0] sm_data;

    video_smoother #(.W(16)) u_smooth (
        .pclk(pclk),
        .presetn(presetn),
        .restart(clear_q || sweep_start),
        .shift(smooth_q),
        .in_valid(sample_valid),
        .in_data(lin_q ? sample.lin_lvl : sample.log_lvl), // [R13]
        .out_valid(sm_valid),
        .out_data(sm_data)
    ); // [R12]

    ////////////////////////////////////////////////////////////////////////////
    // Pixel grouping and detector
    logic [15:0] cnt_q, pmax_q, pmin_q, pfirst_q;
    logic [PW-1:0] pix_q;
    logic [31:0] psum_q, sm, mean_full;
    logic first, pix_end, sweep_end;
    logic [15:0] mx, mn, fs, v;

    always_comb begin
        first = cnt_q == 16'h0000;
        pix_end = sm_valid && cnt_q == 16'((32'h1 << spp_log2_q) - 32'h1); // [R21]
        sweep_end = pix_end && pix_q == PW'(NPTS - 1);
        mx = (first || sm_data > pmax_q) ? sm_data : pmax_q;
        mn = (first || sm_data < pmin_q) ? sm_data : pmin_q;
        fs = first ? sm_data : pfirst_q;
        sm = (first ? 32'h0 : psum_q) + {16'h0000, sm_data};
        mean_full = sm >> spp_log2_q;
        case (det_q)
            DET_PEAK: v = mx; // [R6]
            DET_SAMPLE: v = fs; // [R7]
            DET_MEAN: v = mean_full[15:0]; // [R8]
            DET_MIN: v = mn; // [R9]
            default: v = mx;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            pix_q <= '0;
            pmax_q <= '0;
            pmin_q <= '0;
            pfirst_q <= '0;
            psum_q <= '0;
        end else if (sweep_start || clear_q) begin
            cnt_q <= '0;
            pix_q <= '0;
        end else if (sm_valid) begin
            pmax_q <= mx;
            pmin_q <= mn;
            pfirst_q <= fs;
            psum_q <= sm;
            // Equal share per pixel; surplus samples of a sweep restart at pixel 0
            cnt_q <= pix_end ? 16'h0000 : cnt_q + 16'h0001; // [R21]
            if (pix_end) begin
                pix_q <= sweep_end ? '0 : pix_q + PW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst capture fold
    logic [15:0] burst_mem [NPTS];
    logic [$clog2(BURST_UPDATE + 1)-1:0] upd_cnt_q;
    logic upd_pend_q, publish_q, bfresh_q, in_valid;
    logic [15:0] bfold, in_v;

    always_comb begin
        // Every pixel end folds in with no gap, so short bursts cannot slip [R16]
        bfold = (bfresh_q || v > burst_mem[pix_q]) ? v : burst_mem[pix_q]; // [R15]
        in_valid = pix_end && (!tune_hold || publish_q);
        in_v = tune_hold ? bfold : v; // [R19]
    end

    always_ff @(posedge pclk) begin
        if (pix_end && tune_hold) begin
            burst_mem[pix_q] <= bfold;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_cnt_q <= '0;
            upd_pend_q <= 1'b0;
            publish_q <= 1'b0;
            bfresh_q <= 1'b1;
        end else if (clear_q || !tune_hold) begin
            upd_cnt_q <= '0;
            upd_pend_q <= 1'b0;
            publish_q <= 1'b0;
            bfresh_q <= 1'b1;
        end else begin
            // Rate tick; the fold is published over one whole following sweep [R15]
            if (sweep_end) begin
                publish_q <= upd_pend_q;
                upd_pend_q <= 1'b0;
                bfresh_q <= publish_q;
            end
            // Tick after the consume, so a tick on a sweep end is never lost
            if (upd_cnt_q == ($clog2(BURST_UPDATE + 1))'(BURST_UPDATE - 1)) begin
                upd_cnt_q <= '0;
                upd_pend_q <= 1'b1;
            end else begin
                upd_cnt_q <= upd_cnt_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trace hold stage
    logic [15:0] hold_mem [NPTS];
    logic [15:0] ref_mem [NPTS];
    logic [31:0] sum_mem [NPTS];
    logic fresh_q, avg_last;
    logic [15:0] avg_cnt_q, hold_new, out_v;
    logic [31:0] sum_new, avg_full;

    always_comb begin
        avg_last = avg_cnt_q == 16'((32'h1 << avg_log2_q) - 32'h1);
        sum_new = (avg_cnt_q == 16'h0000 ? 32'h0 : sum_mem[pix_q]) + {16'h0000, in_v};
        avg_full = sum_new >> avg_log2_q;
        hold_new = in_v;
        out_v = in_v;
        case (mode_q)
            TM_LIVE: begin
                out_v = in_v; // [R1]
            end
            TM_MAX: begin
                hold_new = (fresh_q || in_v > hold_mem[pix_q]) ? in_v : hold_mem[pix_q];
                out_v = hold_new; // [R2]
            end
            TM_MIN: begin
                hold_new = (fresh_q || in_v < hold_mem[pix_q]) ? in_v : hold_mem[pix_q];
                out_v = hold_new; // [R3]
            end
            TM_AVG: begin
                // Until the first group completes, the first sweep's value stands in
                hold_new = avg_last ? avg_full[15:0] : (fresh_q ? in_v : hold_mem[pix_q]);
                out_v = hold_new; // [R4]
            end
            TM_DIFF: begin
                out_v = in_v - ref_mem[pix_q]; // [R5]
            end
            default: begin
                out_v = in_v;
            end
        endcase
    end

    always_ff @(posedge pclk) begin
        if (in_valid) begin
            hold_mem[pix_q] <= hold_new;
            sum_mem[pix_q] <= sum_new;
        end
    end

    // Reference capture copies the whole hold trace, one point per clock
    logic ref_busy_q;
    logic [PW-1:0] ref_idx_q;

    always_ff @(posedge pclk) begin
        if (ref_busy_q) begin
            ref_mem[ref_idx_q] <= hold_mem[ref_idx_q]; // [R5]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_busy_q <= 1'b0;
            ref_idx_q <= '0;
        end else if (store_ref_q) begin
            ref_busy_q <= 1'b1;
            ref_idx_q <= '0;
        end else if (ref_busy_q) begin
            ref_busy_q <= ref_idx_q != PW'(NPTS - 1);
            ref_idx_q <= ref_idx_q + PW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fresh_q <= 1'b1;
            avg_cnt_q <= '0;
            sweep_cnt_q <= '0;
        end else if (clear_q) begin
            fresh_q <= 1'b1; // [R20]
            avg_cnt_q <= '0;
            sweep_cnt_q <= '0;
        end else if (in_valid && sweep_end) begin
            fresh_q <= 1'b0;
            avg_cnt_q <= avg_last ? 16'h0000 : avg_cnt_q + 16'h0001;
            sweep_cnt_q <= sweep_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            point_valid <= 1'b0;
            point <= '0;
        end else begin
            point_valid <= in_valid;
            if (in_valid) begin
                point.index <= 16'(pix_q);
                point.value <= out_v;
            end
        end
    end
endmodule : trace_detector_and_hold

//--- design/trace_pkg.sv
// Package: register map, field layout, modes and timing for the trace detector and hold block
package trace_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SPP_LOG2 = 8'h04;
    localparam logic [7:0] OFS_AVG_LOG2 = 8'h08;
    localparam logic [7:0] OFS_SPAN = 8'h0c;
    localparam logic [7:0] OFS_SMOOTH = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_CMD = 8'h18;
    // Control, command and status field positions
    localparam int CTRL_DET_LSB = 0;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_SWEEP_LSB = 5;
    localparam int CTRL_LIN_BIT = 7;
    localparam int CTRL_RESTART_BIT = 8;
    localparam int CMD_STORE_REF_BIT = 0;
    localparam int STATUS_BURST_BIT = 16;
    // Reset values
    localparam logic [3:0] SPP_LOG2_RST = 4'h0;
    localparam logic [3:0] AVG_LOG2_RST = 4'h0;
    localparam logic [3:0] SMOOTH_RST = 4'h0;
    localparam logic [23:0] SPAN_RST = 24'h000000;
    // Burst capture limits
    localparam logic [23:0] BURST_SPAN_MAX_KHZ = 24'h003a98;
    localparam int BURST_TRACES_PER_S = 20000;
    localparam int BURST_MIN_SIGNAL_US = 200;
    localparam int BURST_UPDATES_PER_S = 8;
    localparam int CLK_HZ = 100_000_000;
    localparam int BURST_UPDATE_CYCLES = CLK_HZ / BURST_UPDATES_PER_S;

    typedef enum logic [1:0] {DET_PEAK, DET_SAMPLE, DET_MEAN, DET_MIN} detector_t;
    typedef enum logic [2:0] {TM_LIVE, TM_MAX, TM_MIN, TM_AVG, TM_DIFF} trace_mode_t;
    typedef enum logic [1:0] {SW_FAST, SW_ACCURATE, SW_PURE_SWEPT, SW_BURST} sweep_mode_t;

    localparam detector_t DET_RST = DET_PEAK;

    typedef struct packed {
        logic [15:0] log_lvl;
        logic [15:0] lin_lvl;
    } sample_t;

    typedef struct packed {
        logic [15:0] index;
        logic [15:0] value;
    } trace_point_t;
endpackage : trace_pkg

//--- design/video_smoother.sv
// Video smoothing filter: first-order recursive low-pass on the sample stream
`timescale 1ns/10ps
module video_smoother #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic [3:0] shift,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    output logic [W-1:0] out_data
);
    logic primed_q;
    logic [W+1:0] diff;
    logic [W+1:0] step;

    // Sign-extended difference keeps the step exact for both directions
    always_comb begin
        diff = {2'b00, in_data} - {2'b00, out_data};
        step = $signed(diff) >>> shift;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primed_q <= 1'b0;
            out_data <= '0;
        end else if (restart) begin
            primed_q <= 1'b0;
        end else if (in_valid) begin
            primed_q <= 1'b1;
            // First sample loads directly so the filter does not ramp from zero
            if (!primed_q || shift == 4'h0) begin
                out_data <= in_data;
            end else begin
                out_data <= W'(out_data + step[W-1:0]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= in_valid && !restart;
        end
    end
endmodule : video_smoother

//--- sim/trace_detector_and_hold_sva.sv
// Checker: port-level properties of the trace detector and hold block
`timescale 1ns/10ps
module trace_sva
    import trace_pkg::*;
#(
    parameter int NPTS = 256
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic sample_valid,
    input wire logic point_valid,
    input wire trace_pkg::trace_point_t point,
    input wire logic tune_hold,
    input wire logic [23:0] span_eff_khz
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc_wr;
    assign acc_wr = psel && penable && pwrite;
    ////////////////////////////////////////
    chk_span_clamp: assert property (tune_hold |-> span_eff_khz <= BURST_SPAN_MAX_KHZ)
        else $error("span above burst limit");
    chk_span_write: assert property (acc_wr && paddr == OFS_SPAN |=> span_eff_khz ==
        ((tune_hold && $past(pwdata[23:0]) > BURST_SPAN_MAX_KHZ) ?
        BURST_SPAN_MAX_KHZ : $past(pwdata[23:0])))
        else $error("span not taken from write");
    // Tuning hold may only change in the cycle after a control write
    chk_tune_cause: assert property ($changed(tune_hold) |-> $past(acc_wr && paddr == OFS_CTRL))
        else $error("tune hold moved without control write");
    chk_burst_on: assert property (acc_wr && paddr == OFS_CTRL && pwdata[6:5] == 2'h3 |=> tune_hold)
        else $error("burst mode did not hold tuning");
    chk_burst_off: assert property (acc_wr && paddr == OFS_CTRL && pwdata[6:5] != 2'h3 |=> !tune_hold)
        else $error("tuning held outside burst");
    chk_point_cause: assert property (point_valid |-> $past(sample_valid, 2))
        else $error("point without closing sample");
    chk_index_range: assert property (point_valid |-> point.index < NPTS)
        else $error("point index out of range");
    chk_point_hold: assert property (!point_valid |-> $stable(point))
        else $error("point changed between pulses");
endmodule : trace_sva

bind trace_detector_and_hold trace_sva #(.NPTS(NPTS)) trace_sva_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .sample_valid(sample_valid), .point_valid(point_valid), .point(point),
    .tune_hold(tune_hold), .span_eff_khz(span_eff_khz));

//--- sim/trace_stream_model.sv
// Model of the sample source upstream and the trace memory downstream
`timescale 1ns/10ps
module trace_stream_model
    import trace_pkg::*;
(
    input wire logic pclk,
    output logic sweep_start,
    output logic sample_valid,
    output trace_pkg::sample_t sample,
    input wire logic point_valid,
    input wire trace_pkg::trace_point_t point
);
    logic [15:0] cap [0:15];
    int n_pts;
    initial begin
        sweep_start = 1'b0;
        sample_valid = 1'b0;
        sample = '0;
        n_pts = 0;
    end
    always @(posedge pclk) begin
        if (point_valid === 1'b1) begin
            cap[point.index[3:0]] <= point.value;
            n_pts <= n_pts + 1;
        end
    end
    ////////////////////////////////////////
    // Idle lines show the inverse of the last word, except the closing idle of a slow sweep, which shows the last word again
    task automatic run_sweep(input int n, input int b, input int m, input bit slow);
        n_pts = 0;
        @(posedge pclk);
        sweep_start <= 1'b1;
        @(posedge pclk);
        sweep_start <= 1'b0;
        for (int k = 0; k < n; k++) begin
            sample_valid <= 1'b1;
            sample.log_lvl <= 16'(b + (((k + 1) * m) & 15));
            sample.lin_lvl <= 16'(b + (((k + 1) * m) & 15)) ^ 16'h00ff;
            @(posedge pclk);
            if (slow) begin
                sample_valid <= 1'b0;
                sample <= ~sample;
                @(posedge pclk);
            end
        end
        sample_valid <= 1'b0;
        sample <= ~sample;
        repeat (6) @(posedge pclk);
    endtask : run_sweep
endmodule : trace_stream_model

//--- sim/trace_detector_and_hold_tb.sv
// Testbench: registers, detectors, trace modes and burst capture
`timescale 1ns/10ps
module trace_detector_and_hold_tb;
    import trace_pkg::*;
    localparam int NP = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic sweep_start, sample_valid, point_valid, tune_hold;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] span_eff_khz;
    sample_t sample;
    trace_point_t point;
    int n_fail = 0;
    int samples_checked = 0;
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Short burst tick keeps the publish cadence inside a short run
    trace_detector_and_hold #(.NPTS(NP), .BURST_UPDATE(50)) trace_detector_and_hold_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sweep_start(sweep_start), .sample_valid(sample_valid), .sample(sample),
        .point_valid(point_valid), .point(point), .tune_hold(tune_hold),
        .span_eff_khz(span_eff_khz));
    trace_stream_model trace_stream_model_inst (.pclk(pclk), .sweep_start(sweep_start),
        .sample_valid(sample_valid), .sample(sample), .point_valid(point_valid), .point(point));
    ////////////////////////////////////////
    task automatic results();
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            results();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            #1;
        end
    endtask : apb
    function automatic logic [15:0] sv(input int b, input int m, input int k);
        return 16'(b + (((k + 1) * m) & 15));
    endfunction : sv
    function automatic logic [15:0] cap(input int p);
        return trace_stream_model_inst.cap[p];
    endfunction : cap
    ////////////////////////////////////////
    task automatic t_reg();
        chk(32'({point_valid, tune_hold, span_eff_khz}), 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, OFS_STATUS, 32'hffffffff);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({rd[30:0], err}, 32'h1);
    endtask : t_reg
    task automatic t_det();
        logic [15:0] v, mx, mn, sm, e;
        logic [17:0] d18;
        apb(1'b1, OFS_SPP_LOG2, 32'h2);
        for (int d = 0; d < 5; d++) begin
            apb(1'b1, OFS_CTRL, (d == 4) ? 32'h81 : 32'(d));
            trace_stream_model_inst.run_sweep(NP * 4, 64, 7, d[0]);
            chk(32'(trace_stream_model_inst.n_pts), NP);
            for (int p = 0; p < NP; p++) begin
                mx = 16'h0;
                mn = 16'hffff;
                sm = 16'h0;
                for (int j = 0; j < 4; j++) begin
                    v = sv(64, 7, p * 4 + j);
                    mx = (v > mx) ? v : mx;
                    mn = (v < mn) ? v : mn;
                    sm = sm + v;
                end
                case (d)
                    0: e = mx;
                    1: e = sv(64, 7, p * 4);
                    2: e = sm >> 2;
                    3: e = mn;
                    default: e = sv(64, 7, p * 4) ^ 16'h00ff;
                endcase
                chk(32'(cap(p)), 32'(e));
            end
        end
        // Smoothed stream feeds the sample detector: first smoothed sample per pixel
        apb(1'b1, OFS_SMOOTH, 32'h1);
        trace_stream_model_inst.run_sweep(NP * 4, 64, 7, 1'b0);
        for (int k = 0; k < NP * 4; k++) begin
            v = sv(64, 7, k) ^ 16'h00ff;
            d18 = 18'(v) - 18'(e);
            e = (k == 0) ? v : e + 16'($signed(d18) >>> 1);
            if (k % 4 == 0) begin
                chk(32'(cap(k / 4)), 32'(e));
            end
        end
        apb(1'b1, OFS_SMOOTH, 32'h0);
    endtask : t_det
    task automatic t_modes();
        logic [15:0] a, b, e;
        apb(1'b1, OFS_SPP_LOG2, 32'h0);
        apb(1'b1, OFS_AVG_LOG2, 32'h1);
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, OFS_CTRL, 32'((t << 2) | t));
            trace_stream_model_inst.run_sweep(NP, 100, 7, 1'b0);
            trace_stream_model_inst.run_sweep(NP, 100, 3, 1'b0);
            for (int p = 0; p < NP; p++) begin
                a = sv(100, 7, p);
                b = sv(100, 3, p);
                e = (t == 0) ? b : (t == 1) ? ((a > b) ? a : b) :
                    (t == 2) ? ((a < b) ? a : b) : 16'((17'(a) + 17'(b)) >> 1);
                chk(32'(cap(p)), 32'(e));
            end
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(32'(rd[15:0]), 32'h2);
        end
        apb(1'b1, OFS_CTRL, 32'h10f);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(rd[15:0]), 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0);
        trace_stream_model_inst.run_sweep(NP, 100, 7, 1'b0);
        apb(1'b1, OFS_CMD, 32'h1);
        repeat (NP + 4) @(posedge pclk);
        apb(1'b1, OFS_CTRL, 32'h10);
        trace_stream_model_inst.run_sweep(NP, 100, 3, 1'b0);
        for (int p = 0; p < NP; p++) begin
            chk(32'(cap(p)), 32'(16'(sv(100, 3, p) - sv(100, 7, p))));
        end
    endtask : t_modes
    task automatic t_burst();
        logic [15:0] a, b;
        int tot;
        tot = 0;
        apb(1'b1, OFS_SPAN, 32'd20000);
        chk(32'(span_eff_khz), 32'd20000);
        apb(1'b1, OFS_CTRL, 32'h64);
        chk(32'({tune_hold, span_eff_khz}), 32'h1003a98);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(rd[STATUS_BURST_BIT]), 32'h1);
        for (int s = 0; s < 10; s++) begin
            trace_stream_model_inst.run_sweep(NP, 100, 7 - (s % 2) * 4, 1'b0);
            tot += trace_stream_model_inst.n_pts;
        end
        // Folding means fewer points leave than the ten sweeps bring in
        chk(32'(tot > 0 && tot < 10 * NP), 32'h1);
        for (int p = 0; p < NP; p++) begin
            a = sv(100, 7, p);
            b = sv(100, 3, p);
            chk(32'(cap(p)), 32'((a > b) ? a : b));
        end
        apb(1'b1, OFS_CTRL, 32'h0);
        chk(32'({tune_hold, span_eff_khz}), 32'd20000);
    endtask : t_burst
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        t_reg();
        t_det();
        t_modes();
        t_burst();
        results();
    end
endmodule : trace_detector_and_hold_tb
